// >>> shared/dbsp_params.svh
// Sizes and field positions of the burst-of-four DDR SRAM port
`ifndef DBSP_PARAMS_SVH
`define DBSP_PARAMS_SVH
`define DBSP_ADDR_W 21
`define DBSP_UPPER_W 19
`define DBSP_WORD_W 36
`define DBSP_LANE_W 9
`define DBSP_LANES 4
`define DBSP_BURST 4
`define DBSP_BEAT_W 2
`define DBSP_BANKS 4
`define DBSP_BANK_DEPTH 524288
`endif

// >>> shared/dbsp_pkg.sv
// Types shared by the burst-of-four DDR SRAM port
`include "dbsp_params.svh"
package dbsp_pkg;
  typedef logic [`DBSP_WORD_W-1:0] dbsp_word_t;
  typedef logic [`DBSP_ADDR_W-1:0] dbsp_addr_t;
  typedef logic [`DBSP_UPPER_W-1:0] dbsp_upper_t;
  typedef logic [`DBSP_LANES-1:0] dbsp_lane_n_t;
  typedef logic [`DBSP_BEAT_W-1:0] dbsp_beat_t;
  typedef logic [`DBSP_BURST-1:0][`DBSP_WORD_W-1:0] dbsp_burst_t;
  typedef logic [`DBSP_BURST-1:0][`DBSP_LANES-1:0] dbsp_burst_mask_t;
  typedef enum logic [1:0] {
    DBSP_IDLE = 2'b00,
    DBSP_WRITE = 2'b01,
    DBSP_READ = 2'b10
  } dbsp_core_state_t;
endpackage

// >>> src/dbsp_lane_mem.sv
// Word array split into byte lanes, with registered read data
`timescale 1ns/100ps
`include "dbsp_params.svh"
module dbsp_lane_mem (
  // Clock
  input wire logic mclk,
  // Access
  input wire logic memWe,
  input wire dbsp_pkg::dbsp_addr_t memAddr,
  input wire dbsp_pkg::dbsp_word_t memWrData,
  input wire dbsp_pkg::dbsp_lane_n_t memLaneN,
  // Read data
  output wire dbsp_pkg::dbsp_word_t memRdData
);
  import dbsp_pkg::*;

  // One storage column per lane; a deselected lane keeps its old contents
  for (genvar g = 0; g < `DBSP_LANES; g++) begin : gLane
    logic [`DBSP_LANE_W-1:0] laneArr [0:`DBSP_BANKS*`DBSP_BANK_DEPTH-1]; // RULE13
    logic [`DBSP_LANE_W-1:0] laneRd_q;
    always_ff @(posedge mclk) begin
      if (memWe && !memLaneN[g]) begin // RULE9 RULE10
        laneArr[memAddr] <= memWrData[g*`DBSP_LANE_W +: `DBSP_LANE_W];
      end
      laneRd_q <= laneArr[memAddr];
    end
    assign memRdData[g*`DBSP_LANE_W +: `DBSP_LANE_W] = laneRd_q;
  end
endmodule

// >>> src/dbsp_port.sv
// Burst-of-four DDR SRAM device port: input capture, core sequencer, output launch
//
// Overview of operation
// [RULE1] Write words are taken on rising edges of both input clocks, one each.
// [RULE2] Read words leave on rising edges of the two output clocks alternately.
// [RULE3] In single clock mode the input clock pair launches read words.
// [RULE4] Data drivers are off whenever no read burst is being driven.
// [RULE5] The controller pulls the load strobe low only to start a new access.
// [RULE6] Address and direction are latched together on a load.
// [RULE7] Every access moves exactly four words over two clock periods.
// [RULE8] Lane write selects are taken on the same edge as their data word.
// [RULE9] Select n guards nine-bit lane n of the 36-bit word.
// [RULE10] A deselected lane ignores its data and keeps its stored value.
// [RULE11] One set of address pins serves both reads and writes.
// [RULE12] The two low address bits load a linear burst counter.
// [RULE13] The array holds 2M words of 36 bits in four 512K banks.
// [RULE14] Direction high on a load means read, low means write.
// [RULE15] Commands and addresses are taken on the positive input clock edge.
// [RULE16] With the PLL off the port falls back to shorter legacy read timing.
// [RULE17] The burst counter wraps modulo four inside the aligned group.
// [RULE18] The controller loads at most once per two input clock periods.
`timescale 1ns/100ps
`include "dbsp_params.svh"
module dbsp_port (
  // Core clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Input clock pair
  input wire logic kClk,
  input wire logic kClkN,
  // Output clock pair and mode straps
  input wire logic cClk,
  input wire logic cClkN,
  input wire logic singleClkMode,
  input wire logic pllOffN,
  // Command and address
  input wire logic sequenceLoadN,
  input wire logic readNotWrite,
  input wire dbsp_pkg::dbsp_upper_t addrUpper,
  input wire logic burstStartHigh,
  input wire logic burstStartLow,
  input wire dbsp_pkg::dbsp_lane_n_t byteLaneWriteN,
  // Data pins
  input wire dbsp_pkg::dbsp_word_t dqIn,
  output dbsp_pkg::dbsp_word_t dqOut,
  output logic dqOe
);
  import dbsp_pkg::*;

  // Input clock domain state
  logic kRstN1_q, kRstN2_q, loadNow;
  logic rdTgl_q, rdTgl_d, wrTgl_q, wrTgl_d;
  logic [2:0] wrPh_q, wrPh_d;
  dbsp_addr_t loadAddr, rdAddr_q, rdAddr_d, wrAddr_q, wrAddr_d, wrAddr2_q, wrAddr2_d;
  dbsp_addr_t wrHoldAddr_q, wrHoldAddr_d;
  dbsp_burst_t wrBurst_q, wrBurst_d, wrHold_q, wrHold_d;
  dbsp_burst_mask_t wrMask_q, wrMask_d, wrHoldMask_q, wrHoldMask_d;
  dbsp_word_t negWord_q;
  dbsp_lane_n_t negMask_q;

  // Core domain state
  logic wrS1_q, wrS2_q, wrSeen_q, rdS1_q, rdS2_q, rdSeen_q, wrNew, rdNew;
  logic wrPend_q, wrPend_d, rdPend_q, rdPend_d, rdVal_q, rdVal_d, retTgl_q, retTgl_d;
  dbsp_core_state_t state_q, state_d;
  dbsp_beat_t beat_q, beat_d, rdIdx_q, rdIdx_d;
  dbsp_addr_t curAddr_q, curAddr_d, cWrAddr_q, cWrAddr_d, cRdAddr_q, cRdAddr_d, memAddr;
  dbsp_burst_t cWrBurst_q, cWrBurst_d;
  dbsp_burst_mask_t cWrMask_q, cWrMask_d;
  dbsp_burst_t retSlot_q [2];
  dbsp_burst_t retSlot_d [2];
  logic memWe;
  dbsp_word_t memWrData, memRdData;
  dbsp_lane_n_t memLaneN;

  // Output domain state
  logic oClk, oClkN, oRstN1_q, oRstN2_q, pllS1_q, pllS2_q;
  logic retS1_q, retS2_q, retSeen_q, retNew;
  logic outPend_q, outPend_d, posEn_q, posEn_d, posFirst_q, posFirst_d, negEn_q;
  dbsp_burst_t outBuf_q, outBuf_d, newBurst;
  dbsp_word_t posQ_q, posQ_d, negQ_q;

  // Reset carried into the input clock domain
  always_ff @(posedge kClk) begin
    kRstN1_q <= rst_n;
    kRstN2_q <= kRstN1_q;
  end

  // Load decode and write word assembly on the positive input clock
  always_comb begin
    loadNow = kRstN2_q && !sequenceLoadN; // RULE5 RULE15
    loadAddr = {addrUpper, burstStartHigh, burstStartLow}; // RULE11 RULE12
    rdTgl_d = rdTgl_q;
    rdAddr_d = rdAddr_q;
    wrAddr_d = wrAddr_q;
    wrAddr2_d = wrAddr2_q;
    wrBurst_d = wrBurst_q;
    wrMask_d = wrMask_q;
    wrHold_d = wrHold_q;
    wrHoldMask_d = wrHoldMask_q;
    wrHoldAddr_d = wrHoldAddr_q;
    wrTgl_d = wrTgl_q;
    wrPh_d = {wrPh_q[1:0], loadNow && !readNotWrite}; // RULE14
    if (loadNow && readNotWrite) begin // RULE6 RULE14
      rdAddr_d = loadAddr;
      rdTgl_d = !rdTgl_q;
    end
    if (loadNow && !readNotWrite) begin // RULE6
      wrAddr_d = loadAddr;
    end
    if (wrPh_q[0]) begin // RULE1 RULE8
      wrBurst_d[0] = dqIn;
      wrMask_d[0] = byteLaneWriteN;
    end
    if (wrPh_q[1]) begin // RULE1 RULE8
      wrBurst_d[1] = negWord_q;
      wrMask_d[1] = negMask_q;
      wrBurst_d[2] = dqIn;
      wrMask_d[2] = byteLaneWriteN;
      wrAddr2_d = wrAddr_q;
    end
    if (wrPh_q[2]) begin // RULE7
      wrHold_d = wrBurst_q;
      wrHold_d[3] = negWord_q;
      wrHoldMask_d = wrMask_q;
      wrHoldMask_d[3] = negMask_q;
      wrHoldAddr_d = wrAddr2_q;
      wrTgl_d = !wrTgl_q;
    end
  end

  // Input domain registers
  always_ff @(posedge kClk) begin
    if (!kRstN2_q) begin
      rdTgl_q <= 1'h0;
      wrTgl_q <= 1'h0;
      wrPh_q <= 3'h0;
    end else begin
      rdTgl_q <= rdTgl_d;
      wrTgl_q <= wrTgl_d;
      wrPh_q <= wrPh_d;
    end
    rdAddr_q <= rdAddr_d;
    wrAddr_q <= wrAddr_d;
    wrAddr2_q <= wrAddr2_d;
    wrBurst_q <= wrBurst_d;
    wrMask_q <= wrMask_d;
    wrHold_q <= wrHold_d;
    wrHoldMask_q <= wrHoldMask_d;
    wrHoldAddr_q <= wrHoldAddr_d;
  end

  // Odd write words and their selects on the negative input clock
  always_ff @(posedge kClkN) begin
    negWord_q <= dqIn; // RULE1
    negMask_q <= byteLaneWriteN; // RULE8
  end

  chk_read_load: assert property ( // RULE6
    @(posedge kClk) disable iff (!kRstN2_q)
    (!sequenceLoadN && readNotWrite) |=> (rdTgl_q != $past(rdTgl_q)) && (rdAddr_q == $past(loadAddr))
  ) else $error("read load not latched");

  chk_write_publish: assert property ( // RULE7
    @(posedge kClk) disable iff (!kRstN2_q)
    (!sequenceLoadN && !readNotWrite) |-> ##4 (wrTgl_q != $past(wrTgl_q))
  ) else $error("write burst not handed over three cycles after load");

  chk_write_first: assert property ( // RULE8
    @(posedge kClk) disable iff (!kRstN2_q)
    (!sequenceLoadN && !readNotWrite) |=> ##1 (wrBurst_q[0] == $past(dqIn) && wrMask_q[0] == $past(byteLaneWriteN))
  ) else $error("first write word or select not taken together");

  // Core scheduler: one burst at a time, writes before reads
  always_comb begin
    wrNew = wrS2_q != wrSeen_q;
    rdNew = rdS2_q != rdSeen_q;
    cWrBurst_d = wrNew ? wrHold_q : cWrBurst_q;
    cWrMask_d = wrNew ? wrHoldMask_q : cWrMask_q;
    cWrAddr_d = wrNew ? wrHoldAddr_q : cWrAddr_q;
    cRdAddr_d = rdNew ? rdAddr_q : cRdAddr_q; // RULE11
    wrPend_d = wrPend_q || wrNew;
    rdPend_d = rdPend_q || rdNew;
    state_d = state_q;
    beat_d = beat_q + 2'h1;
    curAddr_d = curAddr_q;
    memWe = 1'h0;
    rdVal_d = 1'h0;
    unique case (state_q)
      DBSP_IDLE: beat_d = 2'h0;
      DBSP_WRITE: memWe = 1'h1;
      DBSP_READ: rdVal_d = 1'h1;
      default: state_d = DBSP_IDLE;
    endcase
    if (state_q == DBSP_IDLE || beat_q == 2'h3) begin // RULE7
      beat_d = 2'h0;
      state_d = DBSP_IDLE;
      if (wrPend_d) begin
        state_d = DBSP_WRITE;
        wrPend_d = 1'h0;
        curAddr_d = cWrAddr_d;
      end else if (rdPend_d) begin
        state_d = DBSP_READ;
        rdPend_d = 1'h0;
        curAddr_d = cRdAddr_d;
      end
    end
    rdIdx_d = beat_q;
    memAddr = {curAddr_q[`DBSP_ADDR_W-1:`DBSP_BEAT_W], 2'(curAddr_q[1:0] + beat_q)}; // RULE12 RULE17
    memWrData = cWrBurst_q[beat_q];
    memLaneN = cWrMask_q[beat_q]; // RULE9
    // Read words gather in the slot the output side is not using
    retSlot_d = retSlot_q;
    retTgl_d = retTgl_q;
    if (rdVal_q) begin
      retSlot_d[!retTgl_q][rdIdx_q] = memRdData;
      if (rdIdx_q == 2'h3) begin
        retTgl_d = !retTgl_q;
      end
    end
  end

  // Core registers, including the event synchronisers
  always_ff @(posedge mclk) begin
    wrS1_q <= wrTgl_q;
    wrS2_q <= wrS1_q;
    rdS1_q <= rdTgl_q;
    rdS2_q <= rdS1_q;
    if (!rst_n) begin
      wrSeen_q <= 1'h0;
      rdSeen_q <= 1'h0;
      wrPend_q <= 1'h0;
      rdPend_q <= 1'h0;
      rdVal_q <= 1'h0;
      retTgl_q <= 1'h0;
      state_q <= DBSP_IDLE;
      beat_q <= 2'h0;
    end else begin
      wrSeen_q <= wrS2_q;
      rdSeen_q <= rdS2_q;
      wrPend_q <= wrPend_d;
      rdPend_q <= rdPend_d;
      rdVal_q <= rdVal_d;
      retTgl_q <= retTgl_d;
      state_q <= state_d;
      beat_q <= beat_d;
    end
    rdIdx_q <= rdIdx_d;
    curAddr_q <= curAddr_d;
    cWrAddr_q <= cWrAddr_d;
    cRdAddr_q <= cRdAddr_d;
    cWrBurst_q <= cWrBurst_d;
    cWrMask_q <= cWrMask_d;
    retSlot_q <= retSlot_d;
  end

  // Storage array
  dbsp_lane_mem uMem (
    .mclk(mclk),
    .memWe(memWe),
    .memAddr(memAddr),
    .memWrData(memWrData),
    .memLaneN(memLaneN),
    .memRdData(memRdData)
  );

  chk_burst_wrap: assert property ( // RULE17
    @(posedge mclk) disable iff (!rst_n)
    (state_q != DBSP_IDLE && beat_q != 2'h0) |-> (memAddr[1:0] == 2'($past(memAddr[1:0]) + 2'h1))
  ) else $error("burst counter did not step by one");

  chk_write_beats: assert property ( // RULE7
    @(posedge mclk) disable iff (!rst_n)
    (state_q == DBSP_WRITE && beat_q == 2'h0) |-> (memWe && state_q == DBSP_WRITE)[*4]
  ) else $error("write burst shorter than four words");

  chk_read_return: assert property ( // RULE7
    @(posedge mclk) disable iff (!rst_n)
    (state_q == DBSP_READ && beat_q == 2'h3) |-> ##2 (retTgl_q != $past(retTgl_q))
  ) else $error("read burst not handed to output side");

  // Output clocks: the input pair stands in when single clock mode is strapped
  assign oClk = singleClkMode ? kClk : cClk; // RULE3
  assign oClkN = singleClkMode ? kClkN : cClkN; // RULE3

  // Output launch sequence; legacy mode starts one period earlier
  always_comb begin
    retNew = retS2_q != retSeen_q;
    newBurst = retSlot_q[retS2_q];
    outBuf_d = retNew ? newBurst : outBuf_q;
    outPend_d = retNew && pllS2_q; // RULE16
    posQ_d = posQ_q;
    posEn_d = 1'h0;
    posFirst_d = 1'h0;
    if ((retNew && !pllS2_q) || outPend_q) begin // RULE2 RULE16
      posQ_d = outPend_q ? outBuf_q[0] : newBurst[0];
      posEn_d = 1'h1;
      posFirst_d = 1'h1;
    end else if (posFirst_q) begin // RULE2
      posQ_d = outBuf_q[2];
      posEn_d = 1'h1;
    end
  end

  // Output registers on the positive output clock
  always_ff @(posedge oClk) begin
    oRstN1_q <= rst_n;
    oRstN2_q <= oRstN1_q;
    pllS1_q <= pllOffN;
    pllS2_q <= pllS1_q;
    retS1_q <= retTgl_q;
    retS2_q <= retS1_q;
    if (!oRstN2_q) begin
      retSeen_q <= 1'h0;
      outPend_q <= 1'h0;
      posEn_q <= 1'h0;
      posFirst_q <= 1'h0;
    end else begin
      retSeen_q <= retS2_q;
      outPend_q <= outPend_d;
      posEn_q <= posEn_d;
      posFirst_q <= posFirst_d;
    end
    outBuf_q <= outBuf_d;
    posQ_q <= posQ_d;
  end

  // Odd read words on the negative output clock
  always_ff @(posedge oClkN) begin
    if (!oRstN2_q) begin
      negEn_q <= 1'h0;
    end else begin
      negEn_q <= posEn_q; // RULE2
    end
    negQ_q <= posFirst_q ? outBuf_q[1] : outBuf_q[3];
  end

  // Pin mux between the two launch registers; drivers off when idle
  always_comb begin
    dqOut = oClk ? posQ_q : negQ_q; // RULE2
    dqOe = oClk ? posEn_q : negEn_q; // RULE4
  end

  chk_out_end: assert property ( // RULE4
    @(posedge oClk) disable iff (!oRstN2_q)
    (posEn_q && !posFirst_q) |=> (!posEn_q || posFirst_q)
  ) else $error("data drivers left on after a burst");

  chk_normal_lat: assert property ( // RULE16
    @(posedge oClk) disable iff (!oRstN2_q)
    (retNew && pllS2_q) |=> ##1 (posEn_q && posFirst_q && posQ_q == $past(outBuf_q[0]))
  ) else $error("normal mode first word not launched one period after arrival");

  chk_legacy_lat: assert property ( // RULE16
    @(posedge oClk) disable iff (!oRstN2_q)
    (retNew && !pllS2_q) |=> (posEn_q && posFirst_q)
  ) else $error("legacy mode first word not launched at arrival");
endmodule

// >>> dv/dbsp_ctrl_model.sv
// Memory controller model: link clocks, load commands and burst data
`timescale 1ns/100ps
module dbsp_ctrl_model (
  // Clock pairs
  output logic kClk,
  output logic kClkN,
  output logic cClk,
  output logic cClkN,
  // Command, address and write data
  output logic sequenceLoadN,
  output logic readNotWrite,
  output dbsp_pkg::dbsp_addr_t addr,
  output dbsp_pkg::dbsp_lane_n_t byteLaneWriteN,
  output dbsp_pkg::dbsp_word_t dqIn,
  // Read return
  input wire dbsp_pkg::dbsp_word_t dqOut,
  input wire logic dqOe
);
  import dbsp_pkg::*;
  // Free-running input pair, output pair skewed by 10 ns
  always #24 kClk = ~kClk;
  assign kClkN = ~kClk;
  assign cClkN = ~cClk;
  initial begin
    kClk = 1'b0;
    cClk = 1'b0;
    sequenceLoadN = 1'b1;
    readNotWrite = 1'b0;
    addr = '0;
    byteLaneWriteN = 4'hf;
    dqIn = '0;
    #10;
    forever #24 cClk = ~cClk;
  end
  // One load strobe carrying address and direction, taken on rising kClk
  task automatic send(input dbsp_addr_t a, input logic rd);
    @(posedge kClk);
    sequenceLoadN <= 1'b0;
    readNotWrite <= rd;
    addr <= a;
    @(posedge kClk);
    sequenceLoadN <= 1'b1;
    addr <= ~a;
    readNotWrite <= ~rd;
  endtask
  // Four words with their selects, one per rising edge of kClk then kClkN
  task automatic wrBurst(input dbsp_addr_t a, input dbsp_burst_t w, input dbsp_burst_mask_t m);
    send(a, 1'b0);
    for (int k = 0; k < 4; k++) begin
      dqIn <= w[k];
      byteLaneWriteN <= m[k];
      if (k[0]) begin
        @(posedge kClkN);
      end else begin
        @(posedge kClk);
      end
    end
    // Released lines flip so stale values cannot pass
    dqIn <= ~w[3];
    byteLaneWriteN <= ~m[3];
    repeat (10) @(posedge kClk);
  endtask
  // One launch edge: output pair, or input pair in single clock mode; settles 1 ns after
  task automatic outEdge(input logic sgl, input logic pos);
    if (sgl && pos) begin
      @(posedge kClk);
    end else if (sgl) begin
      @(posedge kClkN);
    end else if (pos) begin
      @(posedge cClk);
    end else begin
      @(posedge cClkN);
    end
    #1;
  endtask
  // Waits for the burst to open, then takes one word per launch edge while drivers stay on
  task automatic rdBurst(input dbsp_addr_t a, input logic sgl, output dbsp_burst_t w, output logic ok,
      output logic tailOe);
    ok = 1'b0;
    send(a, 1'b1);
    for (int n = 0; n < 40 && !ok; n++) begin
      outEdge(sgl, 1'b1);
      ok = (dqOe === 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        outEdge(sgl, !k[0]);
        ok = ok && (dqOe === 1'b1);
      end
      w[k] = dqOut;
    end
    outEdge(sgl, 1'b1);
    tailOe = dqOe;
    repeat (2) @(posedge kClk);
  endtask
endmodule

// >>> dv/dbsp_port_bench.sv
// Self-checking bench for the burst-of-four DDR SRAM port
`timescale 1ns/100ps
module dbsp_port_bench;
  import dbsp_pkg::*;
  logic mclk;
  logic rst_n;
  logic singleClkMode;
  logic pllOffN;
  logic kClk;
  logic kClkN;
  logic cClk;
  logic cClkN;
  logic sequenceLoadN;
  logic readNotWrite;
  dbsp_addr_t addr;
  dbsp_lane_n_t byteLaneWriteN;
  dbsp_word_t dqIn;
  dbsp_word_t dqOut;
  logic dqOe;
  int errTotal;
  int numChecks;
  int cycles;
  dbsp_word_t expMem [dbsp_addr_t];

  // Core clock
  always #10 mclk = ~mclk;

  dbsp_port dut_u (.mclk(mclk), .rst_n(rst_n), .kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
    .singleClkMode(singleClkMode), .pllOffN(pllOffN), .sequenceLoadN(sequenceLoadN),
    .readNotWrite(readNotWrite), .addrUpper(addr[20:2]), .burstStartHigh(addr[1]),
    .burstStartLow(addr[0]), .byteLaneWriteN(byteLaneWriteN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

  dbsp_ctrl_model ctrl_u (.kClk(kClk), .kClkN(kClkN), .cClk(cClk), .cClkN(cClkN),
    .sequenceLoadN(sequenceLoadN), .readNotWrite(readNotWrite), .addr(addr),
    .byteLaneWriteN(byteLaneWriteN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

  // Compare and count
  task automatic check(input string name, input dbsp_word_t seen, input dbsp_word_t exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write a burst and update the expected array lane by lane
  task automatic writeExp(input dbsp_addr_t a, input dbsp_burst_t w, input dbsp_burst_mask_t m);
    dbsp_addr_t wa;
    ctrl_u.wrBurst(a, w, m);
    for (int k = 0; k < 4; k++) begin
      wa = {a[20:2], 2'(a[1:0] + k)};
      for (int l = 0; l < 4; l++) begin
        if (!m[k][l]) begin
          expMem[wa][9*l +: 9] = w[k][9*l +: 9];
        end
      end
    end
    check("dqOe after write", 36'(dqOe), 36'h0);
  endtask

  // Read a burst and compare it word by word in counter order
  task automatic readExp(input dbsp_addr_t a, input logic sgl = 1'b0);
    dbsp_burst_t got;
    logic ok;
    logic tailOe;
    ctrl_u.rdBurst(a, sgl, got, ok, tailOe);
    check("read burst opened", 36'(ok), 36'h1);
    for (int k = 0; k < 4; k++) begin
      check("read word", got[k], expMem[{a[20:2], 2'(a[1:0] + k)}]);
    end
    check("dqOe after burst", 36'(tailOe), 36'h0);
  endtask

  // No drive on the data pins while nothing is loaded
  task automatic runIdle();
    repeat (20) begin
      @(posedge cClk);
      #1;
      check("dqOe idle", 36'(dqOe), 36'h0);
    end
  endtask

  // Start inside the group so the counter wraps; read from the same start and from one other
  task automatic runWrap();
    writeExp(21'h012342, {36'h444444444, 36'h333333333, 36'h222222222, 36'h111111111}, '0);
    readExp(21'h012342);
    readExp(21'h012341);
  endtask

  // Each word drops a different lane; that lane must keep its old contents
  task automatic runLanes();
    writeExp(21'h012340, {36'hddddddddd, 36'hccccccccc, 36'hbbbbbbbbb, 36'haaaaaaaaa},
      {4'h8, 4'h4, 4'h2, 4'h1});
    readExp(21'h012340);
  endtask

  // Lowest and highest groups of the array stay distinct
  task automatic runExtremes();
    writeExp(21'h000003, {36'h0f0f0f0f0, 36'h123456789, 36'h876543210, 36'h5a5a5a5a5}, '0);
    writeExp(21'h1ffffc, {36'h9abcdef01, 36'h13579bdf0, 36'h2468ace13, 36'h0a0a0a0a0}, '0);
    readExp(21'h000000);
    readExp(21'h1fffff);
  endtask

  // Legacy timing starts the burst early; words and their order must not change
  task automatic runLegacy();
    @(posedge mclk);
    pllOffN <= 1'b0;
    repeat (4) @(posedge cClk);
    readExp(21'h012343);
    readExp(21'h000002);
    @(posedge mclk);
    pllOffN <= 1'b1;
    repeat (4) @(posedge cClk);
  endtask

  // With the strap set the input pair launches the read words
  task automatic runSingle();
    @(posedge mclk);
    singleClkMode <= 1'b1;
    repeat (4) @(posedge kClk);
    writeExp(21'h0abcd1, {36'h7e7e7e7e7, 36'h6d6d6d6d6, 36'h5c5c5c5c5, 36'h4b4b4b4b4}, '0);
    readExp(21'h0abcd1, 1'b1);
    readExp(21'h1ffffe, 1'b1);
    @(posedge mclk);
    singleClkMode <= 1'b0;
    repeat (4) @(posedge cClk);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errTotal++;
      conclude();
    end
  end

  // Reset for eight core cycles, then the scenarios
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    singleClkMode = 1'b0;
    pllOffN = 1'b1;
    errTotal = 0;
    numChecks = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    runIdle();
    runWrap();
    runLanes();
    runExtremes();
    runLegacy();
    runSingle();
    conclude();
  end
endmodule
